// ==== rtl/scsi_dev_end.sv ====
// Contract
// - Three-bit address with select and strobe picks register.
// - DMA grant clears the DMA request.
// - DMA grant routes writes to data register, reads to receive data register.
// - DMA controller uses grant instead of select.
// - Initiator drives ACK low per byte.
// - Target waits ACK after REQ before finishing.
// - Only initiator drives ATN; target samples.
// - Either role may pull BSY low.
// - Only target drives C/D; true means control.
// - SCSI data open-drain, active low, bit 0 LSB.
// - Host data eight bits, tri-state, active high.
// - DMA request only when DMA mode set.
// - End input finishes byte, stops further requests.
// - Only target drives I/O; true means toward initiator.
// - Odd parity generated; checked optionally, not arbitrating.
//
// Controller end of the SCSI host link, with its receive FIFO.
// Assumes the host party runs on i_ref_clk; SCSI lines are asynchronous.
`timescale 1ns/100ps
`include "scsi_link_params.svh"

// ----------------------------------------
// Receive FIFO
// ----------------------------------------
module scsi_rx_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 32
) (
	input wire logic i_ref_clk,
	input wire logic i_srst,
	input wire logic i_clk_en,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg;
	wire push = i_in_valid & o_in_ready;
	wire pop = o_out_valid & i_out_ready;

	assign o_in_ready = (count_reg != (AW+1)'(DEPTH));
	assign o_out_valid = (count_reg != '0);
	assign o_out_data = mem_reg[rd_ptr_reg];

	always_ff @(posedge i_ref_clk) begin
		if (i_clk_en && push) begin
			mem_reg[wr_ptr_reg] <= i_in_data;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else if (i_clk_en) begin
			if (push) wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
			if (pop) rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
			count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : scsi_rx_fifo

// ----------------------------------------
// Controller end
// ----------------------------------------
module scsi_dev_end #(
	parameter int FIFO_DEPTH = 32
) (
	input wire logic i_ref_clk,
	input wire logic i_srst,
	input wire logic i_clk_en,
	scsi_link_if.dev lnk,
	output logic o_parity_error,
	output logic o_dma_stopped
);
	import scsi_link_pkg::*;

	logic [`CTL_W+`DB_W-1:0] sync1_reg;
	logic [`CTL_W+`DB_W-1:0] sync2_reg;
	logic [7:0] out_data_reg;
	logic [7:0] icmd_reg;
	logic [7:0] mode_reg;
	logic [7:0] tcmd_reg;
	logic par_err_reg;
	logic end_flag_reg;
	logic tx_full_reg;
	logic dma_req_reg;
	logic wr_prev_reg;
	logic rd_prev_reg;
	logic [2:0] rd_addr_reg;
	logic [7:0] hd_out_reg;
	logic hd_oe_reg;
	logic [`CTL_W-1:0] ctl_oe_reg;
	logic [`DB_W-1:0] db_oe_reg;
	hs_state_t hs_reg;
	hs_state_t hs_next;
	logic [7:0] read_val;

	// SCSI lines arrive asynchronously; only the second stage is read.
	wire [`CTL_W-1:0] ctl_in = ~sync2_reg[`CTL_W-1:0];
	wire [`DB_W-1:0] db_in = ~sync2_reg[`CTL_W+`DB_W-1:`CTL_W];
	wire req_in = ctl_in[`CTL_REQ];
	wire ack_in = ctl_in[`CTL_ACK];

	wire grant = ~lnk.dma_grant_n;
	wire sel = ~lnk.target_port_select_n | grant;
	wire rd_act = sel & ~lnk.rd_n;
	wire wr_act = sel & ~lnk.wr_n;
	wire [2:0] eff_addr = grant ? (rd_act ? `REG_RX_DATA : `REG_DATA) : lnk.reg_addr;
	wire wr_take = wr_act & ~wr_prev_reg;
	wire rd_end = rd_prev_reg & ~rd_act;

	wire dma_mode = mode_reg[`MODE_DMA];
	wire tgt_mode = mode_reg[`MODE_TARGET];

	wire fifo_in_ready;
	wire fifo_out_valid;
	wire [`DB_W-1:0] fifo_out_data;
	wire fifo_pop = rd_end & (rd_addr_reg == `REG_RX_DATA);
	wire rx_push = (hs_reg == HS_IDLE) & ~tgt_mode & dma_mode & req_in & fifo_in_ready;
	// odd parity check, skipped while arbitrating
	wire rx_par_bad = mode_reg[`MODE_PAR_CHK] & ~mode_reg[`MODE_ARB] & ~(^db_in);

	scsi_rx_fifo #(
		.WIDTH(`DB_W),
		.DEPTH(FIFO_DEPTH)
	) u_rx_fifo (
		.i_ref_clk(i_ref_clk),
		.i_srst(i_srst),
		.i_clk_en(i_clk_en),
		.i_in_valid(rx_push),
		.o_in_ready(fifo_in_ready),
		.i_in_data(db_in),
		.o_out_valid(fifo_out_valid),
		.i_out_ready(fifo_pop),
		.o_out_data(fifo_out_data)
	);

	always_comb begin
		case (eff_addr)
			`REG_DATA: read_val = db_in[7:0];
			`REG_INIT_CMD: read_val = icmd_reg;
			`REG_MODE: read_val = mode_reg;
			`REG_TGT_CMD: read_val = tcmd_reg;
			`REG_BUS_STAT: read_val = {2'h0, ctl_in};
			`REG_STAT: read_val = {end_flag_reg, dma_req_reg, par_err_reg, ~fifo_in_ready, 4'h0};
			`REG_RX_DATA: read_val = fifo_out_data[7:0];
			default: read_val = 8'h00;
		endcase
	end

	always_comb begin
		case (hs_reg)
			HS_IDLE: begin
				if (rx_push) hs_next = HS_ACK;
				else if (tgt_mode && dma_mode && tx_full_reg) hs_next = HS_REQ;
				else hs_next = HS_IDLE;
			end
			HS_ACK: hs_next = req_in ? HS_ACK : HS_IDLE;
			HS_REQ: hs_next = ack_in ? HS_REL : HS_REQ;
			HS_REL: hs_next = ack_in ? HS_REL : HS_IDLE;
			default: hs_next = HS_IDLE;
		endcase
	end

	wire dma_req_next = dma_mode & ~end_flag_reg & ~grant & (tgt_mode ? ~tx_full_reg : fifo_out_valid);
	wire drive_data = icmd_reg[`ICMD_DRIVE] | (tgt_mode & tx_full_reg);

	logic [`CTL_W-1:0] ctl_oe_next;
	always_comb begin
		ctl_oe_next = '0;
		ctl_oe_next[`CTL_ACK] = ~tgt_mode & (icmd_reg[`ICMD_ACK] | (hs_reg == HS_ACK));
		ctl_oe_next[`CTL_ATN] = ~tgt_mode & icmd_reg[`ICMD_ATN];
		ctl_oe_next[`CTL_BSY] = icmd_reg[`ICMD_BSY];
		ctl_oe_next[`CTL_CD] = tgt_mode & tcmd_reg[`TCMD_CD];
		ctl_oe_next[`CTL_IO] = tgt_mode & tcmd_reg[`TCMD_IO];
		ctl_oe_next[`CTL_REQ] = tgt_mode & (tcmd_reg[`TCMD_REQ] | (hs_reg == HS_REQ));
	end

	wire [`DB_W-1:0] db_oe_next = drive_data ? {~(^out_data_reg), out_data_reg} : '0;

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			sync1_reg <= '1;
			sync2_reg <= '1;
		end else if (i_clk_en) begin
			sync1_reg <= {lnk.db_n, lnk.ctl_n};
			sync2_reg <= sync1_reg;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			out_data_reg <= `REG_RESET_VAL;
			icmd_reg <= `REG_RESET_VAL;
			mode_reg <= `REG_RESET_VAL;
			tcmd_reg <= `REG_RESET_VAL;
		end else if (i_clk_en && wr_take) begin
			case (eff_addr)
				`REG_DATA: out_data_reg <= lnk.hd;
				`REG_INIT_CMD: icmd_reg <= lnk.hd;
				`REG_MODE: mode_reg <= lnk.hd;
				`REG_TGT_CMD: tcmd_reg <= lnk.hd;
				default: out_data_reg <= out_data_reg;
			endcase
		end
	end

	// Set terms are placed last so an event in the clearing cycle survives.
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			par_err_reg <= 1'b0;
			end_flag_reg <= 1'b0;
			tx_full_reg <= 1'b0;
		end else if (i_clk_en) begin
			if (rd_end && rd_addr_reg == `REG_CLR) par_err_reg <= 1'b0;
			if (rx_push && rx_par_bad) par_err_reg <= 1'b1;
			if ((wr_take && eff_addr == `REG_STAT) || !dma_mode) end_flag_reg <= 1'b0;
			if (grant && !lnk.transfer_end_n) end_flag_reg <= 1'b1;
			if (hs_reg == HS_REQ && ack_in) tx_full_reg <= 1'b0;
			if (wr_take && eff_addr == `REG_DATA && tgt_mode && dma_mode) tx_full_reg <= 1'b1;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			hs_reg <= HS_IDLE;
			dma_req_reg <= 1'b0;
			wr_prev_reg <= 1'b0;
			rd_prev_reg <= 1'b0;
			rd_addr_reg <= 3'h0;
			ctl_oe_reg <= '0;
			db_oe_reg <= '0;
		end else if (i_clk_en) begin
			hs_reg <= hs_next;
			dma_req_reg <= dma_req_next;
			wr_prev_reg <= wr_act;
			rd_prev_reg <= rd_act;
			if (rd_act) rd_addr_reg <= eff_addr;
			ctl_oe_reg <= ctl_oe_next;
			db_oe_reg <= db_oe_next;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			hd_out_reg <= 8'h00;
			hd_oe_reg <= 1'b0;
			o_parity_error <= 1'b0;
			o_dma_stopped <= 1'b0;
		end else if (i_clk_en) begin
			hd_out_reg <= rd_act ? read_val : 8'h00;
			hd_oe_reg <= rd_act;
			o_parity_error <= par_err_reg;
			o_dma_stopped <= end_flag_reg;
		end
	end

	assign lnk.dma_request = dma_req_reg;
	assign lnk.hd_dev_out = hd_out_reg;
	assign lnk.hd_dev_oe = hd_oe_reg;
	assign lnk.dev_ctl_oe = ctl_oe_reg;
	assign lnk.dev_db_oe = db_oe_reg;
endmodule : scsi_dev_end

// ==== rtl/scsi_far_end.sv ====
// Far end of the SCSI host link: the CPU/DMA controller cycle engine and
// a SCSI peer that acts as target or initiator opposite the controller.
// Assumes the controller end runs on the same i_ref_clk.
`timescale 1ns/100ps
`include "scsi_link_params.svh"

module scsi_far_end (
	input wire logic i_ref_clk,
	input wire logic i_srst,
	input wire logic i_clk_en,
	scsi_link_if.far lnk,
	input wire logic i_cmd_valid,
	input wire logic i_cmd_write,
	input wire logic i_cmd_dma,
	input wire logic i_cmd_end,
	input wire logic [2:0] i_cmd_addr,
	input wire logic [7:0] i_cmd_wdata,
	output logic o_cmd_ready,
	output logic o_rsp_valid,
	output logic [7:0] o_rsp_data,
	output logic o_dma_request,
	input wire logic i_peer_target,
	input wire logic i_peer_valid,
	input wire logic [7:0] i_peer_data,
	input wire logic i_peer_cd,
	input wire logic i_peer_io,
	input wire logic i_peer_atn,
	input wire logic i_peer_bsy,
	output logic o_peer_ready,
	output logic o_peer_rx_valid,
	output logic [7:0] o_peer_rx_data
);
	import scsi_link_pkg::*;

	localparam logic [3:0] STROBE_CYC = 4'(`HOST_STROBE_CYC);

	// ----------------------------------------
	// Host bus cycle engine
	// ----------------------------------------
	hb_state_t hb_reg;
	logic [3:0] cnt_reg;
	logic write_reg;
	logic dma_reg;
	logic end_reg;
	logic [2:0] addr_reg;
	logic [7:0] wdata_reg;
	wire strobe_last = (hb_reg == HB_STROBE) && (cnt_reg == STROBE_CYC - 4'h1);

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			hb_reg <= HB_IDLE;
			cnt_reg <= 4'h0;
			write_reg <= 1'b0;
			dma_reg <= 1'b0;
			end_reg <= 1'b0;
			addr_reg <= 3'h0;
			wdata_reg <= 8'h00;
			o_rsp_valid <= 1'b0;
			o_rsp_data <= 8'h00;
			o_dma_request <= 1'b0;
			o_cmd_ready <= 1'b1;
		end else if (i_clk_en) begin
			o_rsp_valid <= 1'b0;
			o_dma_request <= lnk.dma_request;
			case (hb_reg)
				HB_IDLE: begin
					if (i_cmd_valid) begin
						write_reg <= i_cmd_write;
						dma_reg <= i_cmd_dma;
						end_reg <= i_cmd_end;
						addr_reg <= i_cmd_addr;
						wdata_reg <= i_cmd_wdata;
						o_cmd_ready <= 1'b0;
						hb_reg <= HB_SETUP;
					end
				end
				HB_SETUP: begin
					cnt_reg <= 4'h0;
					hb_reg <= HB_STROBE;
				end
				HB_STROBE: begin
					cnt_reg <= cnt_reg + 4'h1;
					if (strobe_last) begin
						if (!write_reg) o_rsp_data <= lnk.hd;
						hb_reg <= HB_HOLD;
					end
				end
				HB_HOLD: begin
					o_rsp_valid <= 1'b1;
					o_cmd_ready <= 1'b1;
					hb_reg <= HB_IDLE;
				end
				default: begin
					o_cmd_ready <= 1'b1;
					hb_reg <= HB_IDLE;
				end
			endcase
		end
	end

	wire cyc = (hb_reg != HB_IDLE);
	wire strobe = (hb_reg == HB_STROBE);
	assign lnk.reg_addr = addr_reg;
	assign lnk.target_port_select_n = ~(cyc & ~dma_reg);
	assign lnk.dma_grant_n = ~(cyc & dma_reg);
	assign lnk.transfer_end_n = ~(strobe & dma_reg & end_reg);
	assign lnk.rd_n = ~(strobe & ~write_reg);
	assign lnk.wr_n = ~(strobe & write_reg);
	assign lnk.hd_host_out = wdata_reg;
	assign lnk.hd_host_oe = cyc & write_reg;

	// ----------------------------------------
	// SCSI peer
	// ----------------------------------------
	hs_state_t ps_reg;
	logic [`CTL_W+`DB_W-1:0] sync1_reg;
	logic [`CTL_W+`DB_W-1:0] sync2_reg;
	logic [7:0] pdata_reg;
	wire [`CTL_W-1:0] ctl_in = ~sync2_reg[`CTL_W-1:0];
	wire [`DB_W-1:0] db_in = ~sync2_reg[`CTL_W+`DB_W-1:`CTL_W];

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			sync1_reg <= '1;
			sync2_reg <= '1;
			ps_reg <= HS_IDLE;
			pdata_reg <= 8'h00;
			o_peer_ready <= 1'b0;
			o_peer_rx_valid <= 1'b0;
			o_peer_rx_data <= 8'h00;
		end else if (i_clk_en) begin
			sync1_reg <= {lnk.db_n, lnk.ctl_n};
			sync2_reg <= sync1_reg;
			o_peer_ready <= 1'b0;
			o_peer_rx_valid <= 1'b0;
			case (ps_reg)
				HS_IDLE: begin
					if (i_peer_target && i_peer_valid) begin
						pdata_reg <= i_peer_data;
						o_peer_ready <= 1'b1;
						ps_reg <= HS_REQ;
					end else if (!i_peer_target && ctl_in[`CTL_REQ]) begin
						o_peer_rx_data <= db_in[7:0];
						o_peer_rx_valid <= 1'b1;
						ps_reg <= HS_ACK;
					end
				end
				HS_ACK: if (!ctl_in[`CTL_REQ]) ps_reg <= HS_IDLE;
				HS_REQ: if (ctl_in[`CTL_ACK]) ps_reg <= HS_REL;
				HS_REL: if (!ctl_in[`CTL_ACK]) ps_reg <= HS_IDLE;
				default: ps_reg <= HS_IDLE;
			endcase
		end
	end

	// Data is driven from entering the REQ state; REQ itself follows a cycle
	// later through the registered enable, giving setup before the strobe.
	logic req_dly_reg;
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) req_dly_reg <= 1'b0;
		else if (i_clk_en) req_dly_reg <= (ps_reg == HS_REQ);
	end

	wire send = (ps_reg == HS_REQ) | (ps_reg == HS_REL);
	always_comb begin
		lnk.far_ctl_oe = '0;
		lnk.far_ctl_oe[`CTL_REQ] = req_dly_reg & (ps_reg == HS_REQ);
		lnk.far_ctl_oe[`CTL_ACK] = (ps_reg == HS_ACK);
		lnk.far_ctl_oe[`CTL_ATN] = ~i_peer_target & i_peer_atn;
		lnk.far_ctl_oe[`CTL_BSY] = i_peer_bsy;
		lnk.far_ctl_oe[`CTL_CD] = i_peer_target & i_peer_cd;
		lnk.far_ctl_oe[`CTL_IO] = i_peer_target & i_peer_io;
	end
	assign lnk.far_db_oe = send ? {~(^pdata_reg), pdata_reg} : '0;
endmodule : scsi_far_end

// ==== rtl/scsi_link_if.sv ====
// Carrier joining the controller end and the host/peer end.
// Resolves the shared host data bus and the open-drain SCSI lines from
// the output enables of both parties; an undriven line floats high.
`timescale 1ns/100ps
`include "scsi_link_params.svh"

interface scsi_link_if;
	logic [2:0] reg_addr;
	logic target_port_select_n;
	logic rd_n;
	logic wr_n;
	logic dma_grant_n;
	logic transfer_end_n;
	logic dma_request;
	logic [7:0] hd_dev_out;
	logic hd_dev_oe;
	logic [7:0] hd_host_out;
	logic hd_host_oe;
	logic [7:0] hd;
	logic [`CTL_W-1:0] dev_ctl_oe;
	logic [`CTL_W-1:0] far_ctl_oe;
	logic [`CTL_W-1:0] ctl_n;
	logic [`DB_W-1:0] dev_db_oe;
	logic [`DB_W-1:0] far_db_oe;
	logic [`DB_W-1:0] db_n;

	assign hd = hd_dev_oe ? hd_dev_out : (hd_host_oe ? hd_host_out : 8'hff);
	assign ctl_n = ~(dev_ctl_oe | far_ctl_oe);
	assign db_n = ~(dev_db_oe | far_db_oe);

	modport dev (
		input reg_addr, target_port_select_n, rd_n, wr_n, dma_grant_n, transfer_end_n, hd, ctl_n, db_n,
		output dma_request, hd_dev_out, hd_dev_oe, dev_ctl_oe, dev_db_oe
	);
	modport far (
		output reg_addr, target_port_select_n, rd_n, wr_n, dma_grant_n, transfer_end_n,
		output hd_host_out, hd_host_oe, far_ctl_oe, far_db_oe,
		input dma_request, hd, ctl_n, db_n
	);
endinterface : scsi_link_if

// ==== rtl/scsi_link_params.svh ====
// Constants shared by both ends of the SCSI host link: register offsets,
// field positions, reset values, line indices and timing counts.
// Assumes a single reference clock at the rate given below.
`ifndef SCSI_LINK_PARAMS_SVH
`define SCSI_LINK_PARAMS_SVH

// ----------------------------------------
// Register offsets (three-bit address) and register reset value
// ----------------------------------------
`define REG_DATA 3'h0
`define REG_INIT_CMD 3'h1
`define REG_MODE 3'h2
`define REG_TGT_CMD 3'h3
`define REG_BUS_STAT 3'h4
`define REG_STAT 3'h5
`define REG_RX_DATA 3'h6
`define REG_CLR 3'h7
`define REG_RESET_VAL 8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ICMD_DRIVE 0
`define ICMD_ATN 1
`define ICMD_BSY 2
`define ICMD_ACK 4
`define MODE_ARB 0
`define MODE_DMA 1
`define MODE_PAR_CHK 5
`define MODE_TARGET 6
`define TCMD_IO 0
`define TCMD_CD 1
`define TCMD_REQ 3
`define STAT_FIFO_FULL 4
`define STAT_PAR_ERR 5
`define STAT_DMA_REQ 6
`define STAT_DMA_END 7

// ----------------------------------------
// SCSI control and data line indices and widths
// ----------------------------------------
`define CTL_REQ 0
`define CTL_ACK 1
`define CTL_ATN 2
`define CTL_BSY 3
`define CTL_CD 4
`define CTL_IO 5
`define CTL_W 6
`define DB_PAR 8
`define DB_W 9

// ----------------------------------------
// Timing
// ----------------------------------------
`define REF_CLK_MHZ 40
`define HOST_STROBE_NS 75
`define HOST_STROBE_CYC ((`HOST_STROBE_NS * `REF_CLK_MHZ + 999) / 1000)

`endif

// ==== rtl/scsi_link_pkg.sv ====
// Types shared by both ends of the SCSI host link.
// Assumes scsi_link_params.svh supplies the numeric constants.
package scsi_link_pkg;
	typedef enum logic [1:0] {
		HS_IDLE = 2'b00,
		HS_ACK = 2'b01,
		HS_REQ = 2'b10,
		HS_REL = 2'b11
	} hs_state_t;

	typedef enum logic [1:0] {
		HB_IDLE = 2'b00,
		HB_SETUP = 2'b01,
		HB_STROBE = 2'b10,
		HB_HOLD = 2'b11
	} hb_state_t;
endpackage : scsi_link_pkg

// ==== verif/scsi_link_sva.sv ====
// Concurrent checks on the carrier between the controller end and far end.
// Assumes one clock domain and a synchronous, active-high reset.
`timescale 1ns/100ps
`include "scsi_link_params.svh"

module scsi_link_sva (
	input wire logic i_ref_clk,
	input wire logic i_srst,
	input wire logic rd_n,
	input wire logic target_port_select_n,
	input wire logic dma_grant_n,
	input wire logic transfer_end_n,
	input wire logic dma_request,
	input wire logic hd_dev_oe,
	input wire logic [`CTL_W-1:0] dev_ctl_oe,
	input wire logic [`CTL_W-1:0] ctl_n,
	input wire logic [`DB_W-1:0] dev_db_oe
);
	logic rd_sel;
	logic init_side;
	logic tgt_side;

	// A grant counts as a select, so both open a read.
	assign rd_sel = !rd_n && (!target_port_select_n || !dma_grant_n);
	assign init_side = dev_ctl_oe[`CTL_ATN] || dev_ctl_oe[`CTL_ACK];
	assign tgt_side = dev_ctl_oe[`CTL_REQ] || dev_ctl_oe[`CTL_CD] || dev_ctl_oe[`CTL_IO];

	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_srst);

	dma_req_clr_a:
	assert property (!dma_grant_n |=> !dma_request) else $error("dma request stayed up under grant");
	end_stop_a:
	assert property (!transfer_end_n && !dma_grant_n |=> !dma_request [*3]) else $error("request after end");
	hd_drive_only_a:
	assert property (hd_dev_oe |-> $past(rd_sel)) else $error("host data driven outside a read");
	hd_read_prompt_a:
	assert property (rd_sel |=> hd_dev_oe) else $error("host data not driven during read");
	parity_odd_a:
	assert property (dev_ctl_oe[`CTL_REQ] |-> ^dev_db_oe) else $error("even parity on sent byte");
	role_split_a:
	assert property (!(init_side && tgt_side)) else $error("initiator and target lines driven together");
	ack_after_req_a:
	assert property ($rose(dev_ctl_oe[`CTL_ACK]) |-> !ctl_n[`CTL_REQ] && $past(!ctl_n[`CTL_REQ], 2))
		else $error("ack without request");
	req_wait_ack_a:
	assert property ($fell(dev_ctl_oe[`CTL_REQ]) |-> $past(!ctl_n[`CTL_ACK], 2)) else $error("request dropped early");
endmodule : scsi_link_sva

// ==== verif/testbench.sv ====
// Self-checking bench: both link ends joined by the carrier.
// Assumes a 40 MHz clock and the shared constants header.
`timescale 1ns/100ps
`include "scsi_link_params.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("mismatch at %0t got %h exp %h", $time, (g), (e)); end end

module testbench;
	import scsi_link_pkg::*;
	logic ref_clk, srst, cmd_valid, cmd_write, cmd_dma, cmd_end, cmd_ready, rsp_valid, dma_req_q;
	logic peer_target, peer_valid, peer_cd, peer_io, peer_atn, peer_bsy, peer_ready, rx_valid;
	logic parity_error, dma_stopped, ok;
	logic [2:0] cmd_addr;
	logic [7:0] cmd_wdata, rsp_data, peer_data, rx_data, rd, d;
	logic [7:0] v [1:3];
	logic [7:0] mask [1:3] = '{8'h06, 8'h21, 8'h0b};
	logic [7:0] exp_q [$];
	logic [7:0] rx_q [$];
	logic [31:0] seed = 32'h00012e52;
	int error_cnt = 0;
	int n_checks = 0;

	scsi_link_if lnk();
	scsi_dev_end #(.FIFO_DEPTH(32)) i_scsi_dev_end (.i_ref_clk(ref_clk), .i_srst(srst), .i_clk_en(1'h1),
		.lnk(lnk.dev), .o_parity_error(parity_error), .o_dma_stopped(dma_stopped));
	scsi_far_end i_scsi_far_end (.i_ref_clk(ref_clk), .i_srst(srst), .i_clk_en(1'h1), .lnk(lnk.far),
		.i_cmd_valid(cmd_valid), .i_cmd_write(cmd_write), .i_cmd_dma(cmd_dma), .i_cmd_end(cmd_end),
		.i_cmd_addr(cmd_addr), .i_cmd_wdata(cmd_wdata), .o_cmd_ready(cmd_ready), .o_rsp_valid(rsp_valid),
		.o_rsp_data(rsp_data), .o_dma_request(dma_req_q), .i_peer_target(peer_target),
		.i_peer_valid(peer_valid), .i_peer_data(peer_data), .i_peer_cd(peer_cd), .i_peer_io(peer_io),
		.i_peer_atn(peer_atn), .i_peer_bsy(peer_bsy), .o_peer_ready(peer_ready),
		.o_peer_rx_valid(rx_valid), .o_peer_rx_data(rx_data));
	scsi_link_sva i_scsi_link_sva (.i_ref_clk(ref_clk), .i_srst(srst), .rd_n(lnk.rd_n),
		.target_port_select_n(lnk.target_port_select_n), .dma_grant_n(lnk.dma_grant_n),
		.transfer_end_n(lnk.transfer_end_n), .dma_request(lnk.dma_request), .hd_dev_oe(lnk.hd_dev_oe),
		.dev_ctl_oe(lnk.dev_ctl_oe), .ctl_n(lnk.ctl_n), .dev_db_oe(lnk.dev_db_oe));

	initial begin
		ref_clk = 1'h0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// The peer's valid is dropped on the edge after the one that takes the byte; peer_send watches it with a limit in case the byte stalls.
	always @(posedge ref_clk) begin
		if (peer_ready === 1'h1) peer_valid <= 1'h0;
		if (rx_valid === 1'h1) rx_q.push_back(rx_data);
	end

	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction : rnd

	function automatic logic [7:0] bus_stat(input logic io, cd, bsy, atn);
		return {2'h0, io, cd, bsy, atn, 2'h0};
	endfunction : bus_stat

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : wrap_up

	task automatic expire();
		`CHK(1'h0, 1'h1)
		wrap_up();
	endtask : expire

	task automatic cyc(input logic w, dma, fin, input logic [2:0] a, input logic [7:0] wd);
		int k;
		@(negedge ref_clk);
		cmd_valid = 1'h1;
		cmd_write = w;
		cmd_dma = dma;
		cmd_end = fin;
		cmd_addr = a;
		cmd_wdata = wd;
		for (k = 0; cmd_ready !== 1'h1 && k < 50; k++) @(negedge ref_clk);
		if (k >= 50) expire();
		@(negedge ref_clk);
		cmd_valid = 1'h0;
		for (k = 0; rsp_valid !== 1'h1 && k < 50; k++) @(negedge ref_clk);
		if (k >= 50) expire();
		rd = rsp_data;
	endtask : cyc

	task automatic wait_req();
		int k;
		for (k = 0; lnk.dma_request !== 1'h1 && k < 200; k++) @(negedge ref_clk);
		if (k >= 200) expire();
	endtask : wait_req

	task automatic peer_send(input logic [7:0] b, input int lim);
		int k;
		@(negedge ref_clk);
		peer_data = b;
		peer_valid = 1'h1;
		for (k = 0; peer_valid === 1'h1 && k < lim; k++) @(negedge ref_clk);
		ok = !peer_valid;
	endtask : peer_send

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		{cmd_valid, cmd_write, cmd_dma, cmd_end, cmd_addr, cmd_wdata} = '0;
		{peer_target, peer_valid, peer_cd, peer_io, peer_atn, peer_bsy, peer_data} = '0;
		srst = 1'h1;
		repeat (10) @(negedge ref_clk);
		srst = 1'h0;
		for (int a = 1; a < 4; a++) begin
			cyc(1'h0, 1'h0, 1'h0, 3'(a), 8'h00);
			`CHK(rd, 8'h00)
			v[a] = rnd() & mask[a];
			cyc(1'h1, 1'h0, 1'h0, 3'(a), v[a]);
			cyc(1'h0, 1'h0, 1'h0, 3'(a), 8'h00);
			`CHK(rd, v[a])
		end
		cyc(1'h0, 1'h0, 1'h0, 3'h4, 8'h00);
		`CHK(rd, bus_stat(1'h0, 1'h0, v[1][`ICMD_BSY], v[1][`ICMD_ATN]))
		for (int a = 1; a < 4; a++) cyc(1'h1, 1'h0, 1'h0, 3'(a), 8'h00);
		d = rnd();
		{peer_target, peer_cd, peer_io} = {1'h1, d[1:0]};
		cyc(1'h0, 1'h0, 1'h0, 3'h4, 8'h00);
		`CHK(rd, bus_stat(d[0], d[1], 1'h0, 1'h0))
		{peer_target, peer_cd, peer_io, peer_atn, peer_bsy} = 5'h03;
		cyc(1'h0, 1'h0, 1'h0, 3'h4, 8'h00);
		`CHK(rd, bus_stat(1'h0, 1'h0, 1'h1, 1'h1))
		{peer_atn, peer_bsy, peer_target} = 3'h1;
		cyc(1'h1, 1'h0, 1'h0, 3'h2, 8'h22);
		for (int i = 0; i < 32; i++) begin
			exp_q.push_back(rnd());
			peer_send(exp_q[i], 200);
			if (!ok) expire();
		end
		cyc(1'h0, 1'h0, 1'h0, 3'h5, 8'h00);
		`CHK(rd[`STAT_FIFO_FULL], 1'h1)
		`CHK(lnk.dma_request, 1'h1)
		cyc(1'h1, 1'h0, 1'h0, 3'h2, 8'h20);
		`CHK(lnk.dma_request, 1'h0)
		cyc(1'h1, 1'h0, 1'h0, 3'h2, 8'h22);
		exp_q.push_back(rnd());
		peer_send(exp_q[32], 40);
		if (!ok) expire();
		// A wrongly given acknowledge needs several cycles, as REQ must first cross the controller's synchroniser.
		repeat (8) @(negedge ref_clk);
		`CHK(lnk.ctl_n[`CTL_ACK], 1'h1)
		for (int i = 0; i < 33; i++) begin
			wait_req();
			cyc(1'h0, 1'h1, 1'h0, 3'h3, 8'h00);
			d = exp_q.pop_front();
			`CHK(rd, d)
		end
		repeat (4) @(negedge ref_clk);
		`CHK(lnk.dma_request, 1'h0)
		`CHK(peer_valid, 1'h0)
		`CHK(parity_error, 1'h0)
		peer_target = 1'h0;
		cyc(1'h1, 1'h0, 1'h0, 3'h2, 8'h42);
		for (int i = 0; i < 4; i++) begin
			exp_q.push_back(rnd());
			wait_req();
			cyc(1'h1, 1'h1, i == 3, 3'h5, exp_q[i]);
		end
		for (int k = 0; rx_q.size() < 4; k++) begin
			if (k >= 300) expire();
			@(negedge ref_clk);
		end
		for (int i = 0; i < 4; i++) begin
			rd = rx_q.pop_front();
			d = exp_q.pop_front();
			`CHK(rd, d)
		end
		`CHK(dma_stopped, 1'h1)
		`CHK(lnk.dma_request, 1'h0)
		cyc(1'h1, 1'h0, 1'h0, 3'h5, 8'h00);
		cyc(1'h0, 1'h0, 1'h0, 3'h5, 8'h00);
		`CHK(rd[`STAT_DMA_END], 1'h0)
		`CHK(lnk.dma_request, 1'h1)
		`CHK(dma_req_q, 1'h1)
		wrap_up();
	end
endmodule : testbench
